/* rtl/aic_top.sv */
// Analog input conditioning: conversion, readout, scaling and filtering.
`timescale 1ns/1ns
module aic_top #(
  parameter int unsigned MEAS_CYC [aic_pkg::RES_STEPS] = aic_pkg::MEAS_CYC,
  parameter int unsigned CONV_MAX_CYC [aic_pkg::RES_STEPS] =
    aic_pkg::CONV_MAX_CYC
) (
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire logic signed [15:0]   sp_raw_pin,
  input  wire logic signed [15:0]   sel_raw_pin,
  input  wire logic signed [15:0]   act_raw_pin,
  input  wire logic                 fire_pin,
  input  wire logic                 setpoint_polarity_binary_function,
  input  wire logic                 cfg_load,
  input  wire logic [3:0]           main_setpoint_resolution,
  input  wire logic [3:0]           select_in1_resolution,
  input  wire aic_pkg::aic_cfg_type sp_cfg,
  input  wire aic_pkg::aic_cfg_type sel_cfg,
  input  wire aic_pkg::aic_cfg_type act_cfg,
  input  wire logic [7:0]           speed_feedback_source,
  input  wire logic [7:0]           optimization_run_select,
  output logic signed [15:0]        sp_value,
  output logic signed [15:0]        sel_value,
  output logic signed [15:0]        act_value,
  output logic                      sample_strobe,
  output logic                      actual_filter_in_opt
);
  localparam int NCH = aic_pkg::NCH;

  function automatic logic signed [15:0] sat16(
    input logic signed [47:0] v
  );
    if (v > 48'sh000000007fff) begin
      return 16'sh7fff;
    end
    if (v < -48'sh000000008000) begin
      return -16'sh8000;
    end
    return v[15:0];
  endfunction

  function automatic logic cfg_ok(
    input aic_pkg::aic_cfg_type c,
    input logic                 act
  );
    logic sc_ok;
    logic of_ok;
    logic ct_ok;
    sc_ok = act ? (c.scale <= aic_pkg::ACT_SCALE_MAX &&
                   c.scale >= -aic_pkg::ACT_SCALE_MAX)
                : (c.scale <= aic_pkg::SCALE_MAX &&
                   c.scale >= -aic_pkg::SCALE_MAX);
    of_ok = act ? (c.offset <= aic_pkg::ACT_OFS_LIM &&
                   c.offset >= -aic_pkg::ACT_OFS_LIM)
                : (c.offset <= aic_pkg::OFS_MAX &&
                   c.offset >= aic_pkg::OFS_MIN);
    ct_ok = c.ctrl[3:0] <= aic_pkg::MODE_MAX &&
            c.ctrl[7:4] <= (act ? aic_pkg::TAP_MAX : aic_pkg::TYPE_MAX);
    return sc_ok && of_ok && ct_ok && c.filt_ms <= aic_pkg::FILT_MAX_MS;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronizers.

  logic signed [15:0] raw_s1 [NCH];
  logic signed [15:0] raw_s2 [NCH];
  logic               fire_s1;
  logic               fire_s2;
  logic               fire_d;
  logic               pol_s1;
  logic               pol_s2;
  wire logic signed [15:0] raw_pin [NCH];

  assign raw_pin[aic_pkg::CH_SP]  = sp_raw_pin;
  assign raw_pin[aic_pkg::CH_SEL] = sel_raw_pin;
  assign raw_pin[aic_pkg::CH_ACT] = act_raw_pin;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        raw_s1[i] <= 16'sh0000;
        raw_s2[i] <= 16'sh0000;
      end
      fire_s1 <= 1'b0;
      fire_s2 <= 1'b0;
      fire_d  <= 1'b0;
      pol_s1  <= 1'b0;
      pol_s2  <= 1'b0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        raw_s1[i] <= raw_pin[i];
        raw_s2[i] <= raw_s1[i];
      end
      fire_s1 <= fire_pin;
      fire_s2 <= fire_s1;
      fire_d  <= fire_s2;
      pol_s1  <= setpoint_polarity_binary_function;
      pol_s2  <= pol_s1;
    end
  end

  wire fire_edge = fire_s2 & ~fire_d;

  //////////////////////////////////////////////////////////////////////////
  // Settings: a load takes a whole channel only when every field is legal.

  logic [2:0]           res_idx [2];
  aic_pkg::aic_cfg_type cfg [NCH];
  wire logic            cfg_in_ok [NCH];
  wire aic_pkg::aic_cfg_type cfg_in [NCH];

  assign cfg_in[aic_pkg::CH_SP]  = sp_cfg;
  assign cfg_in[aic_pkg::CH_SEL] = sel_cfg;
  assign cfg_in[aic_pkg::CH_ACT] = act_cfg;

  for (genvar c = 0; c < NCH; c++) begin : g_ok
    assign cfg_in_ok[c] = cfg_ok(cfg_in[c], c == aic_pkg::CH_ACT);
  end

  wire sp_res_ok = main_setpoint_resolution >= 4'(aic_pkg::RES_MIN) &&
                   main_setpoint_resolution <= 4'(aic_pkg::RES_MAX);
  wire sel_res_ok = select_in1_resolution >= 4'(aic_pkg::RES_MIN) &&
                    select_in1_resolution <= 4'(aic_pkg::RES_MAX);
  wire [3:0] sp_res_off  = main_setpoint_resolution - 4'(aic_pkg::RES_MIN);
  wire [3:0] sel_res_off = select_in1_resolution - 4'(aic_pkg::RES_MIN);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      res_idx[0]             <= aic_pkg::RES_RST_IDX;
      res_idx[1]             <= aic_pkg::RES_RST_IDX;
      cfg[aic_pkg::CH_SP]    <= aic_pkg::CFG_SP_RST;
      cfg[aic_pkg::CH_SEL]   <= aic_pkg::CFG_SP_RST;
      cfg[aic_pkg::CH_ACT]   <= aic_pkg::CFG_ACT_RST;
    end else if (cfg_load) begin
      if (sp_res_ok) begin
        res_idx[0] <= sp_res_off[2:0];
      end
      if (sel_res_ok) begin
        res_idx[1] <= sel_res_off[2:0];
      end
      for (int i = 0; i < NCH; i++) begin
        if (cfg_in_ok[i]) begin
          cfg[i] <= cfg_in[i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Converters and once-per-firing-cycle readout.

  wire logic signed [15:0] conv_val [NCH];
  wire logic [2:0]         conv_res [NCH];
  logic signed [15:0]      samp [NCH];

  assign conv_res[aic_pkg::CH_SP]  = res_idx[0];
  assign conv_res[aic_pkg::CH_SEL] = res_idx[1];
  assign conv_res[aic_pkg::CH_ACT] = aic_pkg::RES_RST_IDX;

  for (genvar c = 0; c < NCH; c++) begin : g_conv
    aic_conv #(
      .MEAS_CYC     (MEAS_CYC),
      .CONV_MAX_CYC (CONV_MAX_CYC)
    ) u_conv (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .raw     (raw_s2[c]),
      .res_idx (conv_res[c]),
      .value   (conv_val[c]),
      .done    ()
    );
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        samp[i] <= 16'sh0000;
      end
      sample_strobe <= 1'b0;
    end else begin
      sample_strobe <= fire_edge;
      if (fire_edge) begin
        for (int i = 0; i < NCH; i++) begin
          samp[i] <= conv_val[i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Conditioning chain, evaluated once on each readout.

  wire logic signed [15:0] scaled [NCH];
  wire logic signed [15:0] ofs    [NCH];
  wire logic signed [15:0] absv   [NCH];
  wire logic signed [15:0] sgn    [NCH];
  wire logic signed [15:0] fin    [NCH];
  logic signed [15:0]      cond   [NCH];

  for (genvar c = 0; c < NCH; c++) begin : g_chain
    if (c == aic_pkg::CH_ACT) begin : g_act
      wire [3:0] tap = cfg[c].ctrl[7:4];
      wire logic signed [15:0] tap_fs =
        tap == aic_pkg::TAP_HIGH ? aic_pkg::TAP_FS_HIGH :
        tap == aic_pkg::TAP_MID  ? aic_pkg::TAP_FS_MID  :
        aic_pkg::TAP_FS_LOW;
      wire no_in = tap == aic_pkg::TAP_NONE ||
                   cfg[c].scale == 16'sh0000;
      assign scaled[c] = no_in ? 16'sh0000 :
        sat16(48'(samp[c]) * 48'(tap_fs) / 48'(cfg[c].scale));
    end else begin : g_sp
      wire [3:0] ityp = cfg[c].ctrl[7:4];
      wire cur = ityp != aic_pkg::IN_VOLT;
      wire pol_rev = c == aic_pkg::CH_SP && cur && pol_s2;
      wire logic signed [15:0] live = sat16(
        (48'(samp[c]) - 48'(aic_pkg::LIVE_ZERO)) * aic_pkg::LZ_NUM
        / aic_pkg::LZ_DEN);
      wire logic signed [15:0] pre =
        ityp == aic_pkg::IN_4_20 ? live : samp[c];
      wire logic signed [15:0] pre2 =
        pol_rev ? sat16(-48'(pre)) : pre;
      assign scaled[c] =
        sat16(48'(pre2) * 48'(cfg[c].scale) / aic_pkg::PCT_FULL);
    end
    assign ofs[c] = sat16(48'(scaled[c]) + 48'(cfg[c].offset));
    assign absv[c] = ofs[c] < 0 ? sat16(-48'(ofs[c])) : ofs[c];
    assign sgn[c] = cfg[c].ctrl[0] ? absv[c] : ofs[c];
    assign fin[c] = cfg[c].ctrl[1] ? sat16(-48'(sgn[c])) : sgn[c];
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        cond[i] <= 16'sh0000;
      end
    end else if (sample_strobe) begin
      for (int i = 0; i < NCH; i++) begin
        cond[i] <= fin[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Programmable first-order filters, stepped every microsecond.

  logic [6:0]              tdiv;
  logic signed [39:0]      facc [NCH];
  logic signed [15:0]      yv   [NCH];
  wire logic [23:0]        n_us [NCH];
  wire logic signed [40:0] next_acc [NCH];
  wire logic signed [15:0] next_y   [NCH];

  wire ftick = tdiv == 7'(aic_pkg::FILT_TICK_CYC - 1);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tdiv <= 7'h00;
    end else begin
      tdiv <= ftick ? 7'h00 : tdiv + 7'h01;
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_filt
    assign n_us[c] = 24'(32'(cfg[c].filt_ms) * aic_pkg::US_PER_MS);
    assign next_acc[c] = 41'(facc[c]) + 41'(cond[c]) - 41'(yv[c]);
    assign next_y[c] = 16'(next_acc[c] / $signed({1'b0, n_us[c]}));

    always_ff @(posedge clk_sys) begin
      if (!resetn) begin
        facc[c] <= 40'sh0000000000;
        yv[c]   <= 16'sh0000;
      end else if (ftick) begin
        if (n_us[c] == 24'h000000) begin
          facc[c] <= 40'(cond[c]);
          yv[c]   <= cond[c];
        end else begin
          facc[c] <= next_acc[c][39:0];
          yv[c]   <= next_y[c];
        end
      end
    end
  end

  assign sp_value  = yv[aic_pkg::CH_SP];
  assign sel_value = yv[aic_pkg::CH_SEL];
  assign act_value = yv[aic_pkg::CH_ACT];

  wire opt_req = speed_feedback_source == aic_pkg::SPEED_SRC_TACHO &&
                 optimization_run_select == aic_pkg::OPT_RUN_TACHO;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      actual_filter_in_opt <= 1'b0;
    end else begin
      actual_filter_in_opt <= opt_req;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  a_res_default: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    $rose(resetn) |-> res_idx[0] == aic_pkg::RES_RST_IDX &&
                      res_idx[1] == aic_pkg::RES_RST_IDX)
    else $error("resolution not at 12 bits after reset");

  a_fire_sample: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    fire_edge |=> sample_strobe &&
                  samp[aic_pkg::CH_SP] == $past(conv_val[aic_pkg::CH_SP]))
    else $error("firing edge did not take the converted value");

  a_strobe_single: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    sample_strobe |=> !sample_strobe [*2])
    else $error("more than one readout per firing cycle");

  a_act_ofs_range: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    cfg[aic_pkg::CH_ACT].offset <= aic_pkg::ACT_OFS_LIM &&
    cfg[aic_pkg::CH_ACT].offset >= -aic_pkg::ACT_OFS_LIM)
    else $error("actual value offset outside its limit");

  a_ctrl_range: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    cfg[aic_pkg::CH_SP].ctrl[7:4] <= aic_pkg::TYPE_MAX &&
    cfg[aic_pkg::CH_SP].ctrl[3:0] <= aic_pkg::MODE_MAX)
    else $error("setpoint control word outside 00 to 23");

  a_opt_flag: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    opt_req ##1 opt_req |-> actual_filter_in_opt)
    else $error("optimization flag missing for tacho feedback");

  a_abs_nonneg: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    sample_strobe && cfg[aic_pkg::CH_SP].ctrl[1:0] == aic_pkg::SIGN_ABS
    |=> cond[aic_pkg::CH_SP] >= 0)
    else $error("magnitude mode produced a negative value");

  a_abs_neg: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    sample_strobe &&
    cfg[aic_pkg::CH_SP].ctrl[1:0] == aic_pkg::SIGN_ABS_NEG
    |=> cond[aic_pkg::CH_SP] <= 0)
    else $error("negated magnitude mode produced a positive value");

  a_filt_bypass: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ftick && cfg[aic_pkg::CH_SP].filt_ms == 14'h0000
    |=> sp_value == $past(cond[aic_pkg::CH_SP]))
    else $error("zero filter time did not pass the value through");

  a_pol_current: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    sample_strobe && pol_s2 && samp[aic_pkg::CH_SP] > 0 &&
    cfg[aic_pkg::CH_SP] == aic_pkg::aic_cfg_type'{aic_pkg::SCALE_RST,
                             16'sh0000, 8'h20, 14'h0000}
    |=> cond[aic_pkg::CH_SP] < 0)
    else $error("polarity input did not reverse current setpoint");
endmodule

/* rtl/aic_pkg.sv */
// Constants and types shared by the analog input conditioning design.
package aic_pkg;
  localparam int unsigned CLK_MHZ   = 125;
  localparam int unsigned NS_PER_US = 1000;
  localparam int unsigned US_PER_MS = 1000;
  localparam int unsigned RES_MIN   = 10;
  localparam int unsigned RES_MAX   = 14;
  localparam int unsigned RES_STEPS = 5;
  localparam logic [2:0]  RES_RST_IDX = 3'h2;
  localparam logic [2:0]  RES_TOP_IDX = 3'h4;

  localparam int unsigned MEAS_NS [RES_STEPS] =
    '{142200, 284400, 568900, 1137800, 2275600};
  localparam int unsigned CONV_MAX_NS [RES_STEPS] =
    '{416400, 700900, 1269800, 2407600, 4683100};
  localparam int unsigned MEAS_CYC [RES_STEPS] = '{
    (MEAS_NS[0] * CLK_MHZ + NS_PER_US - 1) / NS_PER_US,
    (MEAS_NS[1] * CLK_MHZ + NS_PER_US - 1) / NS_PER_US,
    (MEAS_NS[2] * CLK_MHZ + NS_PER_US - 1) / NS_PER_US,
    (MEAS_NS[3] * CLK_MHZ + NS_PER_US - 1) / NS_PER_US,
    (MEAS_NS[4] * CLK_MHZ + NS_PER_US - 1) / NS_PER_US};
  localparam int unsigned CONV_MAX_CYC [RES_STEPS] = '{
    CONV_MAX_NS[0] * CLK_MHZ / NS_PER_US,
    CONV_MAX_NS[1] * CLK_MHZ / NS_PER_US,
    CONV_MAX_NS[2] * CLK_MHZ / NS_PER_US,
    CONV_MAX_NS[3] * CLK_MHZ / NS_PER_US,
    CONV_MAX_NS[4] * CLK_MHZ / NS_PER_US};
  localparam int unsigned SETTLE_CYC = 32;

  localparam int unsigned HWF_TAU_NS  = 1000000;
  localparam int unsigned HWF_SHIFT   = 7;
  localparam int unsigned HWF_DIV_CYC =
    HWF_TAU_NS * CLK_MHZ / NS_PER_US / (2 ** HWF_SHIFT);
  localparam int unsigned FILT_TICK_NS  = 1000;
  localparam int unsigned FILT_TICK_CYC = FILT_TICK_NS * CLK_MHZ / NS_PER_US;
  localparam logic [13:0] FILT_MAX_MS   = 14'h2710;

  localparam int          PCT_FULL      = 100;
  localparam logic signed [15:0] SCALE_RST     = 16'sh0064;
  localparam logic signed [15:0] SCALE_MAX     = 16'sh03e8;
  localparam logic signed [15:0] OFS_MIN       = -16'sh270f;
  localparam logic signed [15:0] OFS_MAX       = 16'sh4000;
  localparam logic signed [15:0] ACT_OFS_LIM   = 16'sh03e8;
  localparam logic signed [15:0] ACT_SCALE_RST = 16'sh1770;
  localparam logic signed [15:0] ACT_SCALE_MAX = 16'sh6978;
  localparam logic signed [15:0] LIVE_ZERO     = 16'sh0ccd;
  localparam int          LZ_NUM        = 5;
  localparam int          LZ_DEN        = 4;
  localparam logic signed [15:0] TAP_FS_HIGH   = 16'sh61a8;
  localparam logic signed [15:0] TAP_FS_MID    = 16'sh1f40;
  localparam logic signed [15:0] TAP_FS_LOW    = 16'sh09c4;
  localparam logic [7:0]  CTRL_SP_RST   = 8'h00;
  localparam logic [7:0]  CTRL_ACT_RST  = 8'h20;
  localparam logic [3:0]  MODE_MAX      = 4'h3;
  localparam logic [3:0]  TYPE_MAX      = 4'h2;
  localparam logic [3:0]  TAP_MAX       = 4'h3;
  localparam logic [7:0]  SPEED_SRC_TACHO = 8'h01;
  localparam logic [7:0]  OPT_RUN_TACHO   = 8'h1a;
  localparam int          CH_SP  = 0;
  localparam int          CH_SEL = 1;
  localparam int          CH_ACT = 2;
  localparam int          NCH    = 3;

  typedef enum logic [1:0] {
    SIGN_KEEP    = 2'b00,
    SIGN_ABS     = 2'b01,
    SIGN_NEG     = 2'b10,
    SIGN_ABS_NEG = 2'b11
  } aic_sign_type;

  typedef enum logic [3:0] {
    IN_VOLT = 4'h0,
    IN_4_20 = 4'h1,
    IN_0_20 = 4'h2
  } aic_intype_type;

  typedef enum logic [3:0] {
    TAP_NONE = 4'h0,
    TAP_HIGH = 4'h1,
    TAP_MID  = 4'h2,
    TAP_LOW  = 4'h3
  } aic_tap_type;

  typedef struct packed {
    logic signed [15:0] scale;
    logic signed [15:0] offset;
    logic [7:0]         ctrl;
    logic [13:0]        filt_ms;
  } aic_cfg_type;

  localparam aic_cfg_type CFG_SP_RST =
    '{SCALE_RST, 16'sh0000, CTRL_SP_RST, 14'h0000};
  localparam aic_cfg_type CFG_ACT_RST =
    '{ACT_SCALE_RST, 16'sh0000, CTRL_ACT_RST, 14'h0000};
endpackage

/* rtl/aic_conv.sv */
// Averaging converter: fixed input filter, windowed mean, quantizing.
`timescale 1ns/1ns
module aic_conv #(
  parameter int unsigned MEAS_CYC [aic_pkg::RES_STEPS] = aic_pkg::MEAS_CYC,
  parameter int unsigned CONV_MAX_CYC [aic_pkg::RES_STEPS] =
    aic_pkg::CONV_MAX_CYC
) (
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  input  wire logic signed [15:0] raw,
  input  wire logic [2:0]         res_idx,
  output logic signed [15:0]      value,
  output logic                    done
);
  typedef enum logic [0:0] {
    st_measure = 1'b0,
    st_settle  = 1'b1
  } aic_conv_state_type;

  aic_conv_state_type state;
  logic [9:0]         hdiv;
  logic signed [22:0] hacc;
  logic [18:0]        cnt;
  logic [2:0]         ridx;
  logic signed [34:0] acc;
  logic [19:0]        since;
  logic [32:0]        recip [aic_pkg::RES_STEPS];

  for (genvar i = 0; i < aic_pkg::RES_STEPS; i++) begin : g_recip
    assign recip[i] = 33'((64'd1 << 32) / MEAS_CYC[i]);
  end

  // The fixed first-order stage runs on a slow enable from a divider.
  wire hwf_tick = hdiv == 10'(aic_pkg::HWF_DIV_CYC - 1);
  wire signed [15:0] hwf_out = hacc[22:7];
  wire [18:0] meas_end = 19'(MEAS_CYC[ridx] - 1);
  wire settle_end = cnt == 19'(aic_pkg::SETTLE_CYC - 1);
  wire signed [68:0] prod = acc * $signed({1'b0, recip[ridx]});
  wire signed [15:0] avg = prod[47:32];
  wire [15:0] qmask =
    ~((16'h0001 << (aic_pkg::RES_TOP_IDX - ridx)) - 16'h0001);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      hdiv <= 10'h000;
      hacc <= 23'sh000000;
    end else begin
      hdiv <= hwf_tick ? 10'h000 : hdiv + 10'h001;
      if (hwf_tick) begin
        hacc <= hacc + 23'(raw) - (hacc >>> aic_pkg::HWF_SHIFT);
      end
    end
  end

  // A conversion measures, settles, and starts over without any request.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state <= st_measure;
      cnt   <= 19'h00000;
      acc   <= 35'sh000000000;
      ridx  <= aic_pkg::RES_RST_IDX;
      value <= 16'sh0000;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        st_measure: begin
          acc <= acc + 35'(hwf_out);
          cnt <= cnt + 19'h00001;
          if (cnt == meas_end) begin
            state <= st_settle;
            cnt   <= 19'h00000;
          end
        end
        st_settle: begin
          cnt <= cnt + 19'h00001;
          if (cnt == 19'h00000) begin
            value <= avg & qmask;
            done  <= 1'b1;
          end
          if (settle_end) begin
            state <= st_measure;
            cnt   <= 19'h00000;
            acc   <= 35'sh000000000;
            ridx  <= res_idx;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      since <= 20'h00000;
    end else begin
      since <= done ? 20'h00000 : since + 20'h00001;
    end
  end

  wire [19:0] conv_max = 20'(CONV_MAX_CYC[ridx]);

  a_conv_period: assert property (
    @(posedge clk_sys) disable iff (!resetn) since < conv_max)
    else $error("conversion cycle exceeds its maximum duration");

  a_back_to_back: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    state == st_settle && settle_end
    |=> state == st_measure ##1 state == st_measure && cnt == 19'h00001)
    else $error("conversion did not restart immediately");
endmodule

/* test/aic_source.sv */
// Model of the setpoint source, tachometer and firing sync at the pins.
`timescale 1ns/1ns
module aic_source #(
  parameter int FIRE_CYC = 400
) (
  input  wire logic               clk_sys,
  input  wire logic signed [15:0] level,
  output logic signed [15:0]      sp_raw_pin,
  output logic signed [15:0]      sel_raw_pin,
  output logic signed [15:0]      act_raw_pin,
  output logic                    fire_pin = 1'b0
);
  int cnt = 0;
  assign sp_raw_pin  = level;
  assign sel_raw_pin = level;
  assign act_raw_pin = level;
  // The firing sync is a square wave; each rising edge is one firing cycle.
  always @(posedge clk_sys) begin
    cnt <= (cnt == FIRE_CYC - 1) ? 0 : cnt + 1;
    fire_pin <= (cnt < FIRE_CYC / 2);
  end
endmodule

/* test/analog_input_conditioning_bench.sv */
// Self-checking bench for the analog input conditioning block.
`timescale 1ns/1ns
module analog_input_conditioning_bench;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic signed [15:0] level = 16'sh0000;
  logic signed [15:0] sp_raw_pin, sel_raw_pin, act_raw_pin;
  logic fire_pin, sample_strobe, actual_filter_in_opt;
  logic setpoint_polarity_binary_function = 1'b0;
  logic cfg_load = 1'b0;
  logic [3:0] main_setpoint_resolution = 4'hc;
  logic [3:0] select_in1_resolution = 4'hc;
  aic_pkg::aic_cfg_type sp_cfg = aic_pkg::CFG_SP_RST;
  aic_pkg::aic_cfg_type sel_cfg = aic_pkg::CFG_SP_RST;
  aic_pkg::aic_cfg_type act_cfg = aic_pkg::CFG_ACT_RST;
  logic [7:0] speed_feedback_source = 8'h00;
  logic [7:0] optimization_run_select = 8'h00;
  logic signed [15:0] sp_value, sel_value, act_value, e_sp, e_sel, e_act;
  logic [1:0] m;
  int o, a;
  int num_errors = 0;
  int n_checks = 0;
  always #4 clk_sys = ~clk_sys;
  aic_source src_u (.clk_sys, .level, .sp_raw_pin, .sel_raw_pin,
    .act_raw_pin, .fire_pin);
  aic_top #(.MEAS_CYC('{40, 80, 160, 320, 640}),
    .CONV_MAX_CYC('{200, 300, 500, 800, 1400})) dut_u (.clk_sys, .resetn,
    .sp_raw_pin, .sel_raw_pin, .act_raw_pin, .fire_pin,
    .setpoint_polarity_binary_function, .cfg_load, .main_setpoint_resolution,
    .select_in1_resolution, .sp_cfg, .sel_cfg, .act_cfg,
    .speed_feedback_source, .optimization_run_select, .sp_value, .sel_value,
    .act_value, .sample_strobe, .actual_filter_in_opt);
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic report_and_stop();
    $display("Checks: %0d, mismatches: %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits for a firing edge, then checks the one-cycle readout strobe.
  task automatic fire_wait();
    int k;
    k = 0;
    while (fire_pin !== 1'b0 && k < 900) begin
      step();
      k++;
    end
    if (fire_pin !== 1'b0) begin
      k = 1800;
    end
    while (fire_pin !== 1'b1 && k < 1800) begin
      step();
      k++;
    end
    if (k >= 1800) begin
      num_errors++;
      report_and_stop();
    end else begin
      repeat (2) step();
      check(sample_strobe, 16'h0000);
      step();
      check(sample_strobe, 16'h0001);
      step();
      check(sample_strobe, 16'h0000);
    end
  endtask
  task automatic load_settle();
    cfg_load = 1'b1;
    step();
    cfg_load = 1'b0;
    fire_wait();
    fire_wait();
    repeat (130) step();
  endtask
  function automatic logic signed [15:0] sgn(logic signed [15:0] v,
                                             logic [1:0] md);
    logic signed [15:0] r;
    r = (md[0] && v < 0) ? -v : v;
    return md[1] ? -r : r;
  endfunction
  initial begin
    void'($urandom(32'h2cbd695d));
    level = 16'(16'h1000 + $urandom_range(16'h0fff));
    repeat (16) step();
    resetn = 1'b1;
    step();
    check(sp_value, 16'sh0000);
    check(act_value, 16'sh0000);
    for (int i = 0; i < 16; i++) begin
      o = (i == 0) ? 16384 : (i == 1) ? -9999 : $urandom_range(26383) - 9999;
      a = (i == 0) ? 1000 : $urandom_range(2000) - 1000;
      m = i[1:0];
      sp_cfg = '{16'sh0000, 16'(o), {4'($urandom_range(2)), 2'b00, m}, 14'h0};
      sel_cfg = '{16'sh0000, 16'(o), {4'($urandom_range(2)), 2'b00, ~m}, 14'h0};
      act_cfg = '{16'sh0000, 16'(a),
        {4'($urandom_range(3, 1)), 2'b00, m}, 14'h0};
      main_setpoint_resolution = 4'(10 + $urandom_range(4));
      select_in1_resolution = 4'(10 + $urandom_range(4));
      setpoint_polarity_binary_function = 1'($urandom_range(1));
      e_sp = sgn(16'(o), m);
      e_sel = sgn(16'(o), ~m);
      e_act = sgn(16'(a), m);
      load_settle();
      check(sp_value, e_sp);
      check(sel_value, e_sel);
      check(act_value, e_act);
    end
    sp_cfg.offset = 16'sh4001;
    sel_cfg.ctrl = 8'h24;
    act_cfg.offset = 16'sh03e9;
    load_settle();
    check(sp_value, e_sp);
    check(sel_value, e_sel);
    check(act_value, e_act);
    // A positive level stays positive at the reset settings; a negative scale, reversed polarity or live zero make it negative, no tap zero.
    sp_cfg = aic_pkg::CFG_SP_RST;
    sel_cfg = '{-aic_pkg::SCALE_RST, 16'sh0000, 8'h00, 14'h0};
    act_cfg = aic_pkg::CFG_ACT_RST;
    setpoint_polarity_binary_function = 1'b0;
    load_settle();
    check(sp_value > 0 && sp_value <= level, 16'h0001);
    check(sel_value < 0, 16'h0001);
    check(act_value > 0, 16'h0001);
    sp_cfg.ctrl = 8'h20;
    sel_cfg = '{aic_pkg::SCALE_RST, 16'sh0000, 8'h10, 14'h0};
    act_cfg.ctrl = 8'h00;
    setpoint_polarity_binary_function = 1'b1;
    load_settle();
    check(sp_value < 0, 16'h0001);
    check(sel_value < 0, 16'h0001);
    check(act_value, 16'sh0000);
    speed_feedback_source = 8'h01;
    optimization_run_select = 8'h1a;
    repeat (2) step();
    check(actual_filter_in_opt, 16'h0001);
    optimization_run_select = 8'h19;
    repeat (2) step();
    check(actual_filter_in_opt, 16'h0000);
    report_and_stop();
  end
endmodule
